//--- twc_device.sv
`default_nettype none
module twc_device
    import twc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    twc_link_if.device link,
    output logic [5:0]  swallowCountSet0,
    output logic [11:0] feedbackDivSet0,
    output logic [11:0] referenceDivSet0,
    output logic [5:0]  swallowCountSet1,
    output logic [11:0] feedbackDivSet1,
    output logic [11:0] referenceDivSet1,
    output logic        loadPulse
);
    import twc_pkg::*;
    // =====================================================================
    // input synchronisers
    logic csS, clkS, ioS;
    twc_sync uCs  (.sys_clk(sys_clk), .nrst(nrst), .asyncIn(link.chipSel), .syncOut(csS));
    twc_sync uClk (.sys_clk(sys_clk), .nrst(nrst), .asyncIn(link.serClk),  .syncOut(clkS));
    twc_sync uIo  (.sys_clk(sys_clk), .nrst(nrst), .asyncIn(link.ioLine),  .syncOut(ioS));
    logic csD_r, clkD_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            csD_r  <= 1'b0;
            clkD_r <= 1'b0;
        end else begin
            csD_r  <= csS;
            clkD_r <= clkS;
        end
    end
    wire clkRise = csS & clkS & ~clkD_r;
    wire clkFall = csS & ~clkS & clkD_r;
    wire csFall  = ~csS & csD_r;
    // =====================================================================
    // register storage: live copy and staged copy
    logic [7:0] live_r  [NUM_REGS];
    logic [7:0] stage_r [NUM_REGS];
    logic [NUM_REGS-1:0] dirty_r;
    // =====================================================================
    // serial shifter
    logic [CNT_W-1:0] bitCnt_r;
    logic [7:0]       shift_r;
    logic             cmdDone_r;
    logic             isRead_r;
    logic [ADDR_W-1:0] addr_r;
    wire [7:0] shiftNxt = {shift_r[6:0], ioS};
    always_ff @(posedge sys_clk) begin
        if (!nrst || !csS) begin
            bitCnt_r  <= '0;
            shift_r   <= '0;
            cmdDone_r <= 1'b0;
            isRead_r  <= 1'b0;
            addr_r    <= '0;
        end else if (clkFall) begin
            shift_r  <= shiftNxt;
            bitCnt_r <= bitCnt_r + 3'h1;
            if (bitCnt_r == BIT_LAST) begin
                if (!cmdDone_r) begin
                    addr_r    <= shiftNxt[7:1];
                    isRead_r  <= (shiftNxt[0] == DIR_READ);
                    cmdDone_r <= 1'b1;
                end else begin
                    addr_r <= addr_r + 7'h1;
                end
            end
        end
    end
    wire wrOctet = clkFall && (bitCnt_r == BIT_LAST) && cmdDone_r && !isRead_r;
    // =====================================================================
    // staging and load on falling select
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            dirty_r <= '0;
        end else if (csFall) begin
            dirty_r <= '0;
        end else if (wrOctet) begin
            dirty_r[addr_r] <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (wrOctet) begin
            stage_r[addr_r] <= shiftNxt & twc_reg_mask(addr_r);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_REGS; i++) live_r[i] <= REG_RESET;
        end else if (csFall) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (dirty_r[i]) live_r[i] <= stage_r[i];
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) loadPulse <= 1'b0;
        else       loadPulse <= csFall;
    end
    // =====================================================================
    // read driver
    logic [7:0] rdShift_r;
    logic [CNT_W-1:0] rdCnt_r;
    logic [ADDR_W-1:0] rdAddr_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst || !csS) begin
            link.devIoOe  <= 1'b0;
            link.devIoOut <= 1'b0;
            rdShift_r     <= '0;
            rdCnt_r       <= '0;
            rdAddr_r      <= '0;
        end else if (clkRise && cmdDone_r && isRead_r) begin
            if (!link.devIoOe || rdCnt_r == 3'h0) begin
                // fresh octet: current live contents, addr advances per octet
                link.devIoOe  <= 1'b1;
                link.devIoOut <= live_r[link.devIoOe ? rdAddr_r : addr_r][7];
                rdShift_r     <= {live_r[link.devIoOe ? rdAddr_r : addr_r][6:0], 1'b0};
                rdAddr_r      <= (link.devIoOe ? rdAddr_r : addr_r) + 7'h1;
                rdCnt_r       <= 3'h7;
            end else begin
                link.devIoOut <= rdShift_r[7];
                rdShift_r     <= {rdShift_r[6:0], 1'b0};
                rdCnt_r       <= rdCnt_r - 3'h1;
            end
        end
    end
    // =====================================================================
    // divider outputs: set0 zero tone and receive, set1 one tone
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            swallowCountSet0 <= '0;
            feedbackDivSet0  <= '0;
            referenceDivSet0 <= '0;
            swallowCountSet1 <= '0;
            feedbackDivSet1  <= '0;
            referenceDivSet1 <= '0;
        end else begin
            swallowCountSet0 <= live_r[SWALLOW_COUNT_SET0_ADDR][5:0];
            feedbackDivSet0  <= {live_r[FEEDBACK_DIV_SET0_HIGH_ADDR][3:0],
                                 live_r[FEEDBACK_DIV_SET0_LOW_ADDR]};
            referenceDivSet0 <= {live_r[REFERENCE_DIV_SET0_HIGH_ADDR][3:0],
                                 live_r[REFERENCE_DIV_SET0_LOW_ADDR]};
            swallowCountSet1 <= live_r[SWALLOW_COUNT_SET1_ADDR][5:0];
            feedbackDivSet1  <= {live_r[FEEDBACK_DIV_SET1_HIGH_ADDR][3:0],
                                 live_r[FEEDBACK_DIV_SET1_LOW_ADDR]};
            // low byte of the set1 reference lives one address above
            referenceDivSet1 <= {live_r[REFERENCE_DIV_SET1_HIGH_ADDR][3:0],
                                 live_r[REFERENCE_DIV_SET1_HIGH_ADDR + 7'h1]};
        end
    end
endmodule
`default_nettype wire

//--- twc_pkg.sv
`default_nettype none
package twc_pkg;
    // =====================================================================
    // link framing
    localparam int ADDR_W      = 7;
    localparam int OCTET_W     = 8;
    localparam int CNT_W       = 3;
    localparam int NUM_REGS    = 128;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic       DIR_READ = 1'h1;
    // =====================================================================
    // divider register map (register index on the link)
    localparam logic [6:0] SWALLOW_COUNT_SET0_ADDR       = 7'h0a;
    localparam logic [6:0] FEEDBACK_DIV_SET0_HIGH_ADDR   = 7'h0b;
    localparam logic [6:0] FEEDBACK_DIV_SET0_LOW_ADDR    = 7'h0c;
    localparam logic [6:0] REFERENCE_DIV_SET0_HIGH_ADDR  = 7'h0d;
    localparam logic [6:0] REFERENCE_DIV_SET0_LOW_ADDR   = 7'h0e;
    localparam logic [6:0] SWALLOW_COUNT_SET1_ADDR       = 7'h0f;
    localparam logic [6:0] FEEDBACK_DIV_SET1_HIGH_ADDR   = 7'h10;
    localparam logic [6:0] FEEDBACK_DIV_SET1_LOW_ADDR    = 7'h11;
    localparam logic [6:0] REFERENCE_DIV_SET1_HIGH_ADDR  = 7'h12;
    localparam logic [7:0] SWALLOW_MASK  = 8'h3f;
    localparam logic [7:0] NIBBLE_MASK   = 8'h0f;
    localparam logic [7:0] FULL_MASK     = 8'hff;
    localparam logic [7:0] REG_RESET     = 8'h00;
    // =====================================================================
    // host wishbone registers (byte addresses)
    localparam logic [3:0] HOST_CTRL_ADDR   = 4'h0;
    localparam logic [3:0] HOST_TXDATA_ADDR = 4'h4;
    localparam logic [3:0] HOST_RXDATA_ADDR = 4'h8;
    localparam logic [3:0] HOST_STATUS_ADDR = 4'hc;
    localparam int  CTRL_START_BIT = 0;
    localparam int  CTRL_END_BIT   = 1;
    localparam int  CTRL_READ_BIT  = 2;
    localparam int  STAT_BUSY_BIT  = 0;
    localparam int  STAT_OPEN_BIT  = 1;
    // each link clock phase lasts HALF_CYC + 1 sys_clk cycles: the counter runs through zero
    localparam int  LINK_HALF_NS  = 200;
    localparam int  SYS_CLK_NS    = 50;
    localparam logic [3:0] HALF_CYC = 4'((LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [3:0] CS_SETUP_CYC = 4'h2;
    function automatic logic [7:0] twc_reg_mask(input logic [6:0] a);
        case (a)
            SWALLOW_COUNT_SET0_ADDR, SWALLOW_COUNT_SET1_ADDR: return SWALLOW_MASK;
            FEEDBACK_DIV_SET0_HIGH_ADDR, REFERENCE_DIV_SET0_HIGH_ADDR,
            FEEDBACK_DIV_SET1_HIGH_ADDR, REFERENCE_DIV_SET1_HIGH_ADDR: return NIBBLE_MASK;
            default: return FULL_MASK;
        endcase
    endfunction
endpackage
`default_nettype wire

//--- twc_link_if.sv
`default_nettype none
interface twc_link_if;
    logic chipSel;
    logic serClk;
    logic hostIoOut;
    logic hostIoOe;
    logic devIoOut;
    logic devIoOe;
    wire  ioLine = hostIoOe ? hostIoOut : (devIoOe ? devIoOut : 1'b1);
    modport host   (output chipSel, output serClk, output hostIoOut, output hostIoOe,
                    input ioLine);
    modport device (input chipSel, input serClk, output devIoOut, output devIoOe,
                    input ioLine);
endinterface
`default_nettype wire

//--- twc_sync.sv
`default_nettype none
module twc_sync (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic asyncIn,
    output var  logic syncOut
);
    logic meta_r;
    // meta_r is read only by the second stage
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            meta_r  <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- twc_host.sv
`default_nettype none
module twc_host
    import twc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    twc_link_if.host         link,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    import twc_pkg::*;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01, ST_SETUP = 5'h02, ST_LOW = 5'h04, ST_HIGH = 5'h08, ST_CLOSE = 5'h10
    } twc_state_type;
    twc_state_type state_r;
    logic ioS;
    twc_sync uIo (.sys_clk(sys_clk), .nrst(nrst), .asyncIn(link.ioLine), .syncOut(ioS));
    logic [7:0] tx_r, rx_r;
    logic [2:0] bit_r;
    logic [3:0] cnt_r;
    logic       rdOctet_r, open_r, start_r, close_r;
    logic       busy;
    assign busy = (state_r != ST_IDLE);
    wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wrCtrl = wbReq & wb_we_i & (wb_adr_i == HOST_CTRL_ADDR) & wb_sel_i[0];
    wire wrTx   = wbReq & wb_we_i & (wb_adr_i == HOST_TXDATA_ADDR) & wb_sel_i[0];
    // =====================================================================
    // wishbone slave: one wait state, unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wbReq;
            case (wb_adr_i)
                HOST_TXDATA_ADDR: wb_dat_o <= {24'h0, tx_r};
                HOST_RXDATA_ADDR: wb_dat_o <= {24'h0, rx_r};
                HOST_STATUS_ADDR: wb_dat_o <= {30'h0, open_r, busy};
                default:          wb_dat_o <= '0;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            tx_r <= '0;
            rdOctet_r <= 1'b0;
        end else begin
            if (wrTx) tx_r <= wb_dat_i[7:0];
            if (wrCtrl) rdOctet_r <= wb_dat_i[CTRL_READ_BIT];
        end
    end
    // =====================================================================
    // link engine: octet per start; end closes the frame
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r        <= ST_IDLE;
            link.chipSel   <= 1'b0;
            link.serClk    <= 1'b0;
            link.hostIoOut <= 1'b0;
            link.hostIoOe  <= 1'b1;
            open_r         <= 1'b0;
            bit_r          <= '0;
            cnt_r          <= '0;
            rx_r           <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (wrCtrl && wb_dat_i[CTRL_END_BIT] && open_r) begin
                        state_r <= ST_CLOSE;
                        cnt_r   <= HALF_CYC;
                    end else if (wrCtrl && wb_dat_i[CTRL_START_BIT]) begin
                        link.chipSel  <= 1'b1;
                        open_r        <= 1'b1;
                        link.hostIoOe <= ~wb_dat_i[CTRL_READ_BIT];
                        bit_r         <= BIT_LAST;
                        cnt_r         <= open_r ? HALF_CYC : CS_SETUP_CYC;
                        state_r       <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_r == 4'h0) begin
                        // data changes with the rising edge; device samples on fall
                        link.serClk    <= 1'b1;
                        link.hostIoOut <= tx_r[bit_r];
                        cnt_r          <= HALF_CYC;
                        state_r        <= ST_HIGH;
                    end else cnt_r <= cnt_r - 4'h1;
                end
                ST_HIGH: begin
                    if (cnt_r == 4'h0) begin
                        link.serClk <= 1'b0;
                        cnt_r   <= HALF_CYC;
                        state_r <= ST_LOW;
                    end else cnt_r <= cnt_r - 4'h1;
                end
                ST_LOW: begin
                    // ioS lags two flops: this tap shows the line as it stood at the fall
                    if (rdOctet_r && cnt_r == HALF_CYC - 4'h1) rx_r <= {rx_r[6:0], ioS};
                    if (cnt_r == 4'h0) begin
                        if (bit_r == 3'h0) state_r <= ST_IDLE;
                        else begin
                            bit_r          <= bit_r - 3'h1;
                            link.serClk    <= 1'b1;
                            link.hostIoOut <= tx_r[bit_r - 3'h1];
                            cnt_r          <= HALF_CYC;
                            state_r        <= ST_HIGH;
                        end
                    end else cnt_r <= cnt_r - 4'h1;
                end
                ST_CLOSE: begin
                    // select drops first; the line is taken back only after the
                    // device has seen select low and let go of it
                    if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
                    else if (link.chipSel) begin
                        link.chipSel <= 1'b0;
                        cnt_r        <= HALF_CYC;
                    end else begin
                        link.hostIoOe <= 1'b1;
                        open_r        <= 1'b0;
                        state_r       <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- twc_link_asserts.sv
`default_nettype none
// =====================================================================
// link-level checks, fed with the wires of the shared interface
module twc_link_asserts (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic chipSel,
    input wire logic serClk,
    input wire logic hostIoOut,
    input wire logic hostIoOe,
    input wire logic devIoOut,
    input wire logic devIoOe,
    input wire logic ioLine
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       clkQ;
    logic [3:0] riseCnt;
    logic [2:0] bitCnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // rise count saturates so a long read burst cannot wrap back to nine
    always_ff @(posedge sys_clk) begin
        clkQ <= serClk;
        if (!nrst || !chipSel) begin
            riseCnt <= 4'h0;
            bitCnt  <= 3'h0;
        end else if (serClk && !clkQ) begin
            riseCnt <= (riseCnt == 4'hf) ? riseCnt : riseCnt + 4'h1;
            bitCnt  <= bitCnt + 3'h1;
        end
    end
    a_no_contention: assert property (!(hostIoOe && devIoOe))
        else $error("both ends drive the data line");
    a_dev_quiet: assert property (!chipSel [*4] |-> !devIoOe)
        else $error("device drives outside a frame");
    a_host_hold: assert property ($fell(serClk) && hostIoOe |-> $stable(hostIoOut) [*3])
        else $error("host data moved after falling edge");
    a_dev_hold: assert property ($fell(serClk) && devIoOe |-> $stable(devIoOut) [*3])
        else $error("device data moved after falling edge");
    a_clk_idle: assert property (!chipSel |-> !serClk)
        else $error("link clock runs outside a frame");
    a_clk_high: assert property ($rose(serClk) |-> serClk [*5] ##1 !serClk)
        else $error("link clock high phase wrong");
    a_clk_low: assert property ($fell(serClk) |-> !serClk [*5])
        else $error("link clock low phase too short");
    a_whole_octets: assert property ($fell(chipSel) |-> bitCnt == 3'h0)
        else $error("frame closed mid octet");
    a_cs_setup: assert property ($rose(chipSel) |-> !serClk [*2])
        else $error("clock too soon after select");
    a_read_start: assert property ($rose(devIoOe) |-> chipSel && riseCnt == 4'h9)
        else $error("device turned line at wrong edge");
    c_frame_open: cover property ($rose(chipSel));
    c_frame_close: cover property ($fell(chipSel));
    c_read_turn: cover property ($rose(devIoOe));
    c_read_zero: cover property (devIoOe && !ioLine);
endmodule
`default_nettype wire

//--- tb_three_wire_config_port.sv
`default_nettype none
module tb_three_wire_config_port;
    timeunit 1ns;
    timeprecision 1ps;
    import twc_pkg::*;
    // longest power-up time of the far end, in 50 ns cycles
    localparam int POWER_UP_CYC = 68000;
    localparam logic [7:0] WVAL [9] = '{8'hff, 8'hab, 8'h5c, 8'hf7, 8'h3e, 8'hc1, 8'h96,
                                        8'h24, 8'hed};
    // unused divider bits read back as zero
    localparam logic [7:0] EXPV [9] = '{8'h3f, 8'h0b, 8'h5c, 8'h07, 8'h3e, 8'h01, 8'h06,
                                        8'h24, 8'h0d};
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [3:0]  wbAdr = 4'h0;
    logic [3:0]  wbSel = 4'h1;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic [5:0]  swallowCountSet0;
    logic [11:0] feedbackDivSet0;
    logic [11:0] referenceDivSet0;
    logic [5:0]  swallowCountSet1;
    logic [11:0] feedbackDivSet1;
    logic [11:0] referenceDivSet1;
    logic        loadPulse;
    logic        monClkQ = 1'b0;
    logic [7:0]  monShift = 8'h0;
    int          error_cnt = 0;
    int          cmp_count = 0;
    always #25 sys_clk = ~sys_clk;
    twc_link_if link ();
    twc_host twc_host_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));
    twc_device twc_device_inst (.sys_clk(sys_clk), .nrst(nrst), .link(link),
        .swallowCountSet0(swallowCountSet0), .feedbackDivSet0(feedbackDivSet0),
        .referenceDivSet0(referenceDivSet0), .swallowCountSet1(swallowCountSet1),
        .feedbackDivSet1(feedbackDivSet1), .referenceDivSet1(referenceDivSet1),
        .loadPulse(loadPulse));
    twc_link_asserts twc_link_asserts_inst (.sys_clk(sys_clk), .nrst(nrst),
        .chipSel(link.chipSel), .serClk(link.serClk), .hostIoOut(link.hostIoOut),
        .hostIoOe(link.hostIoOe), .devIoOut(link.devIoOut), .devIoOe(link.devIoOe),
        .ioLine(link.ioLine));
    // =====================================================================
    // wire monitor: shifts the line in on each falling link clock edge
    always @(posedge sys_clk) begin
        monClkQ <= link.serClk;
        if (monClkQ && !link.serClk && link.chipSel) begin
            monShift <= {monShift[6:0], link.ioLine};
        end
    end
    // =====================================================================
    // tasks
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= wd;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 100);
        if (wbAck !== 1'b1) error_cnt++;
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic xfer_octet(input logic [7:0] tx, input logic rd, input logic [7:0] exp);
        logic [31:0] d;
        int n;
        if (!rd) wb_xfer(1'b1, HOST_TXDATA_ADDR, {24'h0, tx}, d);
        wb_xfer(1'b1, HOST_CTRL_ADDR, rd ? 32'h5 : 32'h1, d);
        n = 0;
        do begin
            wb_xfer(1'b0, HOST_STATUS_ADDR, 32'h0, d);
            n++;
        end while (d[STAT_BUSY_BIT] !== 1'b0 && n < 200);
        cmp_val(32'(d[STAT_BUSY_BIT]), 32'h0);
        cmp_val({24'h0, monShift}, {24'h0, rd ? exp : tx});
        if (rd) begin
            wb_xfer(1'b0, HOST_RXDATA_ADDR, 32'h0, d);
            cmp_val(d, {24'h0, exp});
        end
    endtask
    // the load strobe follows every falling select, read frames included
    task automatic close_frame();
        logic [31:0] d;
        int n;
        wb_xfer(1'b1, HOST_CTRL_ADDR, 32'h2, d);
        n = 0;
        while (loadPulse !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        cmp_val(32'(loadPulse), 32'h1);
        repeat (2) @(posedge sys_clk);
        wb_xfer(1'b0, HOST_STATUS_ADDR, 32'h0, d);
        cmp_val(32'(d[STAT_OPEN_BIT]), 32'h0);
    endtask
    // =====================================================================
    // tests
    initial begin
        repeat (90000) @(posedge sys_clk);
        error_cnt++;
        $display("watchdog expired at %0t", $time);
        complete_run();
    end
    initial begin
        logic [31:0] d;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (POWER_UP_CYC) @(posedge sys_clk);
        xfer_octet({SWALLOW_COUNT_SET0_ADDR, 1'b0}, 1'b0, 8'h0);
        for (int i = 0; i < 9; i++) xfer_octet(WVAL[i], 1'b0, 8'h0);
        cmp_val(32'(swallowCountSet0), 32'h0);
        close_frame();
        cmp_val(32'(swallowCountSet0), 32'h3f);
        cmp_val(32'(feedbackDivSet0), 32'hb5c);
        cmp_val(32'(referenceDivSet0), 32'h73e);
        cmp_val(32'(swallowCountSet1), 32'h01);
        cmp_val(32'(feedbackDivSet1), 32'h624);
        cmp_val(32'(referenceDivSet1[11:8]), 32'hd);
        $display("test 1 burst write finished");
        xfer_octet({SWALLOW_COUNT_SET0_ADDR, DIR_READ}, 1'b0, 8'h0);
        for (int i = 0; i < 9; i++) xfer_octet(8'h0, 1'b1, EXPV[i]);
        close_frame();
        $display("test 2 burst read finished");
        xfer_octet({FEEDBACK_DIV_SET0_LOW_ADDR, 1'b0}, 1'b0, 8'h0);
        xfer_octet(8'h81, 1'b0, 8'h0);
        close_frame();
        cmp_val(32'(feedbackDivSet0), 32'hb81);
        cmp_val(32'(swallowCountSet0), 32'h3f);
        xfer_octet({FEEDBACK_DIV_SET0_LOW_ADDR, DIR_READ}, 1'b0, 8'h0);
        xfer_octet(8'h0, 1'b1, 8'h81);
        close_frame();
        $display("test 3 single access finished");
        wb_xfer(1'b0, 4'h2, 32'h0, d);
        cmp_val(d, 32'h0);
        $display("test 4 unmapped read finished");
        complete_run();
    end
endmodule
`default_nettype wire
